/* File: common/dcs_pkg.sv */
// constants, field layout and carrier types of the converter serial port
// assumes a 24-bit word-addressed processor memory port with 32-bit data
package dcs_pkg;

  // processor memory port
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;

  // register word addresses
  localparam logic [23:0] ADDR_GCTL  = 24'h808040;
  localparam logic [23:0] ADDR_XPCTL = 24'h808042;
  localparam logic [23:0] ADDR_RPCTL = 24'h808043;
  localparam logic [23:0] ADDR_TCTL  = 24'h808044;
  localparam logic [23:0] ADDR_TCNT  = 24'h808045;
  localparam logic [23:0] ADDR_TPRD  = 24'h808046;
  localparam logic [23:0] ADDR_XBUF  = 24'h808048;
  localparam logic [23:0] ADDR_RBUF  = 24'h80804C;

  // reset values
  localparam logic [31:0] REG_RESET  = 32'h0000_0000;
  localparam logic        TRANSMIT_READY_FLAG_RESET = 1'b1;

  // global control fields
  localparam int GCTL_RECEIVE_READY_FLAG_BIT    = 0;
  localparam int GCTL_TRANSMIT_READY_FLAG_BIT    = 1;
  localparam int GCTL_FS_INT_BIT  = 2;
  localparam int GCTL_CLK_INT_BIT = 6;
  localparam int GCTL_XINT_EN_BIT = 18;
  localparam int GCTL_RINT_EN_BIT = 20;

  // serial word layout
  localparam int          WORD_BITS       = 16;
  localparam logic [3:0]  LAST_BIT        = 4'hF;
  localparam int          DAC_RSEL_HI_BIT = 15;
  localparam int          DAC_FAST_BIT    = 14;
  localparam int          DAC_PWR_BIT     = 13;
  localparam int          DAC_RSEL_LO_BIT = 12;
  localparam int          DATA_MSB        = 11;
  localparam int          CMD_MSB         = 15;
  localparam int          CMD_LSB         = 12;
  localparam logic [3:0]  ADC_CMD_CONFIG  = 4'hA;

  // internal data clock timing
  localparam int SYS_CLK_MHZ   = 20;
  localparam int LINK_HALF_NS  = 100;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [23:0] addr;
    logic [31:0] wdata;
  } dcs_bus_req_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SYNC  = 2'b01,
    TX_SHIFT = 2'b11
  } dcs_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_SHIFT = 2'b01,
    RX_HOLD  = 2'b11
  } dcs_rx_state_t;

endpackage : dcs_pkg

/* File: logic/dcs_sync_bit.sv */
// two flip-flop level synchroniser
// assumes d is quasi-static relative to clk
`timescale 1ns/1ns
module dcs_sync_bit (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // level in and out
  input  wire logic d,
  output logic      q
);

  logic meta_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : dcs_sync_bit

/* File: logic/dcs_serial_port.sv */
// frame-synchronised serial port shared by a serial ADC and a dual DAC
// assumes a word-addressed processor memory port on clk_sys and that the
// receive clock comes from the converter outside
`timescale 1ns/1ns
module dcs_serial_port (
  // system clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  // processor memory port
  input  wire dcs_pkg::dcs_bus_req_t bus_req,
  output logic [31:0]                bus_rdata,
  // interrupt enables and flags toward the processor
  input  wire logic                  cpu_tx_int_en,
  input  wire logic                  cpu_rx_int_en,
  output logic                       tx_int_flag,
  output logic                       rx_int_flag,
  // transmit clock pin
  input  wire logic                  transmit_clock_i,
  output logic                       transmit_clock_o,
  output logic                       transmit_clock_oe,
  // transmit frame sync pin
  input  wire logic                  transmit_frame_sync_i,
  output logic                       transmit_frame_sync_o,
  output logic                       transmit_frame_sync_oe,
  // transmit data pin
  output logic                       transmit_data_pin,
  // receive side, on the receive clock
  input  wire logic                  receive_clock,
  input  wire logic                  receive_frame_sync,
  input  wire logic                  receive_data_pin
);

  logic [31:0]           gctl_reg;
  logic [31:0]           xpctl_reg;
  logic [31:0]           rpctl_reg;
  logic [31:0]           tctl_reg;
  logic [31:0]           tcnt_reg;
  logic [31:0]           tprd_reg;
  logic [31:0]           xbuf_reg;
  logic                  xbuf_full_reg;
  logic                  transmit_ready_flag_reg;
  logic                  transmit_ready_flag_prev_reg;
  logic [31:0]           rbuf_reg;
  logic                  receive_ready_flag_reg;
  logic                  receive_ready_flag_prev_reg;
  logic                  ack_tgl_reg;
  logic [3:0]            div_cnt_reg;
  logic                  tclk_int_reg;
  logic                  tclk_ext_s;
  logic                  tclk_ext_prev_reg;
  logic                  fs_ext_s;
  dcs_pkg::dcs_tx_state_t tx_state_reg;
  logic [15:0]           xsr_reg;
  logic                  xsr_full_reg;
  logic [3:0]            tx_cnt_reg;
  logic                  rx_tgl_s;
  logic                  rx_tgl_prev_reg;
  dcs_pkg::dcs_rx_state_t rx_state_reg;
  logic [15:0]           rsr_reg;
  logic [3:0]            rx_cnt_reg;
  logic [15:0]           rx_hold_reg;
  logic                  rx_tgl_reg;
  logic                  ack_s;
  logic                  rx_pending;
  logic                  wr_gctl;
  logic                  wr_xbuf;
  logic                  rd_rbuf;
  logic                  clk_int;
  logic                  fs_int;
  logic                  div_wrap;
  logic                  tx_tick;
  logic                  tx_load;
  logic                  rx_word_in;
  logic [15:0]           rsr_next;

  assign clk_int    = gctl_reg[dcs_pkg::GCTL_CLK_INT_BIT];
  assign fs_int     = gctl_reg[dcs_pkg::GCTL_FS_INT_BIT];
  assign wr_gctl    = bus_req.wr && (bus_req.addr == dcs_pkg::ADDR_GCTL);
  assign wr_xbuf    = bus_req.wr && (bus_req.addr == dcs_pkg::ADDR_XBUF);
  assign rd_rbuf    = bus_req.rd && (bus_req.addr == dcs_pkg::ADDR_RBUF);
  assign div_wrap   = div_cnt_reg == 4'(dcs_pkg::LINK_HALF_CYC - 1);
  assign tx_load    = !xsr_full_reg && xbuf_full_reg && (tx_state_reg == dcs_pkg::TX_IDLE);
  assign rx_word_in = rx_tgl_s != rx_tgl_prev_reg;

  // shifts on the falling edge of the data clock, whichever end makes it
  assign tx_tick = clk_int ? (div_wrap && tclk_int_reg)
                           : (!tclk_ext_s && tclk_ext_prev_reg);
  assign transmit_clock_oe      = gctl_reg[dcs_pkg::GCTL_CLK_INT_BIT];
  assign transmit_frame_sync_oe = gctl_reg[dcs_pkg::GCTL_FS_INT_BIT];
  assign transmit_clock_o       = tclk_int_reg;

  // pin and cross-domain synchronisers
  dcs_sync_bit u_sync_tclk (
    .clk   (clk_sys),
    .rst_b (rst_b),
    .d     (transmit_clock_i),
    .q     (tclk_ext_s)
  );
  dcs_sync_bit u_sync_fsx (
    .clk   (clk_sys),
    .rst_b (rst_b),
    .d     (transmit_frame_sync_i),
    .q     (fs_ext_s)
  );
  dcs_sync_bit u_sync_rx_tgl (
    .clk   (clk_sys),
    .rst_b (rst_b),
    .d     (rx_tgl_reg),
    .q     (rx_tgl_s)
  );
  dcs_sync_bit u_sync_ack (
    .clk   (receive_clock),
    .rst_b (rst_b),
    .d     (ack_tgl_reg),
    .q     (ack_s)
  );

  // control registers, all 32 bits wide
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gctl_reg  <= dcs_pkg::REG_RESET;
      xpctl_reg <= dcs_pkg::REG_RESET;
      rpctl_reg <= dcs_pkg::REG_RESET;
      tctl_reg  <= dcs_pkg::REG_RESET;
      tcnt_reg  <= dcs_pkg::REG_RESET;
      tprd_reg  <= dcs_pkg::REG_RESET;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        dcs_pkg::ADDR_GCTL:  gctl_reg  <= bus_req.wdata;
        dcs_pkg::ADDR_XPCTL: xpctl_reg <= bus_req.wdata;
        dcs_pkg::ADDR_RPCTL: rpctl_reg <= bus_req.wdata;
        dcs_pkg::ADDR_TCTL:  tctl_reg  <= bus_req.wdata;
        dcs_pkg::ADDR_TCNT:  tcnt_reg  <= bus_req.wdata;
        dcs_pkg::ADDR_TPRD:  tprd_reg  <= bus_req.wdata;
        default: begin
        end
      endcase
    end
  end

  // read data, one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_rdata <= dcs_pkg::REG_RESET;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        dcs_pkg::ADDR_GCTL:  bus_rdata <= {gctl_reg[31:2], transmit_ready_flag_reg, receive_ready_flag_reg};
        dcs_pkg::ADDR_XPCTL: bus_rdata <= xpctl_reg;
        dcs_pkg::ADDR_RPCTL: bus_rdata <= rpctl_reg;
        dcs_pkg::ADDR_TCTL:  bus_rdata <= tctl_reg;
        dcs_pkg::ADDR_TCNT:  bus_rdata <= tcnt_reg;
        dcs_pkg::ADDR_TPRD:  bus_rdata <= tprd_reg;
        dcs_pkg::ADDR_RBUF:  bus_rdata <= rbuf_reg;
        default:             bus_rdata <= dcs_pkg::REG_RESET;
      endcase
    end
  end

  // transmit buffer and transmit-ready; a load beats a same-cycle write for ready, but the write keeps the buffer full
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      xbuf_reg      <= dcs_pkg::REG_RESET;
      xbuf_full_reg <= 1'b0;
      transmit_ready_flag_reg      <= dcs_pkg::TRANSMIT_READY_FLAG_RESET;
      transmit_ready_flag_prev_reg <= dcs_pkg::TRANSMIT_READY_FLAG_RESET;
      tx_int_flag   <= 1'b0;
    end else begin
      transmit_ready_flag_prev_reg <= transmit_ready_flag_reg;
      tx_int_flag   <= transmit_ready_flag_reg && !transmit_ready_flag_prev_reg && cpu_tx_int_en
                       && gctl_reg[dcs_pkg::GCTL_XINT_EN_BIT];
      if (wr_xbuf) begin
        xbuf_reg      <= bus_req.wdata;
        xbuf_full_reg <= 1'b1;
      end else if (tx_load) begin
        xbuf_full_reg <= 1'b0;
      end
      if (tx_load) begin
        transmit_ready_flag_reg <= 1'b1;
      end else if (wr_xbuf) begin
        transmit_ready_flag_reg <= 1'b0;
      end
    end
  end

  // internal data clock divider, free running
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_reg       <= 4'h0;
      tclk_int_reg      <= 1'b0;
      tclk_ext_prev_reg <= 1'b0;
    end else begin
      tclk_ext_prev_reg <= tclk_ext_s;
      if (div_wrap) begin
        div_cnt_reg  <= 4'h0;
        tclk_int_reg <= !tclk_int_reg;
      end else begin
        div_cnt_reg <= div_cnt_reg + 4'h1;
      end
    end
  end

  // transmit shift register and frame sequence
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_state_reg          <= dcs_pkg::TX_IDLE;
      xsr_reg               <= 16'h0000;
      xsr_full_reg          <= 1'b0;
      tx_cnt_reg            <= 4'h0;
      transmit_data_pin     <= 1'b0;
      transmit_frame_sync_o <= 1'b0;
    end else begin
      case (tx_state_reg)
        dcs_pkg::TX_IDLE: begin
          if (tx_load) begin
            xsr_reg      <= xbuf_reg[15:0];
            xsr_full_reg <= 1'b1;
          end else if (xsr_full_reg && tx_tick && (fs_int || fs_ext_s)) begin
            tx_state_reg          <= dcs_pkg::TX_SYNC;
            transmit_frame_sync_o <= fs_int;
          end
        end
        dcs_pkg::TX_SYNC: begin
          if (tx_tick) begin
            // frame sync falls as the first bit goes out
            tx_state_reg          <= dcs_pkg::TX_SHIFT;
            transmit_frame_sync_o <= 1'b0;
            transmit_data_pin     <= xsr_reg[15];
            xsr_reg               <= {xsr_reg[14:0], 1'b0};
            tx_cnt_reg            <= 4'h0;
          end
        end
        dcs_pkg::TX_SHIFT: begin
          if (tx_tick) begin
            if (tx_cnt_reg == dcs_pkg::LAST_BIT) begin
              tx_state_reg      <= dcs_pkg::TX_IDLE;
              xsr_full_reg      <= 1'b0;
              transmit_data_pin <= 1'b0;
            end else begin
              transmit_data_pin <= xsr_reg[15];
              xsr_reg           <= {xsr_reg[14:0], 1'b0};
              tx_cnt_reg        <= tx_cnt_reg + 4'h1;
            end
          end
        end
        default: begin
          tx_state_reg <= dcs_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // receive side on the receive clock
  assign rx_pending = rx_tgl_reg != ack_s;
  assign rsr_next   = {rsr_reg[14:0], receive_data_pin};

  always_ff @(posedge receive_clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_state_reg <= dcs_pkg::RX_IDLE;
      rsr_reg      <= 16'h0000;
      rx_cnt_reg   <= 4'h0;
      rx_hold_reg  <= 16'h0000;
      rx_tgl_reg   <= 1'b0;
    end else begin
      case (rx_state_reg)
        dcs_pkg::RX_IDLE: begin
          if (receive_frame_sync) begin
            rx_state_reg <= dcs_pkg::RX_SHIFT;
            rx_cnt_reg   <= 4'h0;
          end
        end
        dcs_pkg::RX_SHIFT: begin
          rsr_reg    <= rsr_next;
          rx_cnt_reg <= rx_cnt_reg + 4'h1;
          if (rx_cnt_reg == dcs_pkg::LAST_BIT) begin
            if (rx_pending) begin
              rx_state_reg <= dcs_pkg::RX_HOLD;
            end else begin
              rx_hold_reg  <= rsr_next;
              rx_tgl_reg   <= !rx_tgl_reg;
              rx_state_reg <= dcs_pkg::RX_IDLE;
            end
          end
        end
        dcs_pkg::RX_HOLD: begin
          // frozen: input ignored until the buffer is read
          if (!rx_pending) begin
            rx_hold_reg  <= rsr_reg;
            rx_tgl_reg   <= !rx_tgl_reg;
            rx_state_reg <= dcs_pkg::RX_IDLE;
          end
        end
        default: begin
          rx_state_reg <= dcs_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // receive buffer and receive-ready; a new word beats a same-cycle read
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rbuf_reg        <= dcs_pkg::REG_RESET;
      receive_ready_flag_reg        <= 1'b0;
      receive_ready_flag_prev_reg   <= 1'b0;
      rx_tgl_prev_reg <= 1'b0;
      ack_tgl_reg     <= 1'b0;
      rx_int_flag     <= 1'b0;
    end else begin
      rx_tgl_prev_reg <= rx_tgl_s;
      receive_ready_flag_prev_reg   <= receive_ready_flag_reg;
      rx_int_flag     <= receive_ready_flag_reg && !receive_ready_flag_prev_reg && cpu_rx_int_en
                         && gctl_reg[dcs_pkg::GCTL_RINT_EN_BIT];
      if (rd_rbuf && receive_ready_flag_reg) begin
        ack_tgl_reg <= !ack_tgl_reg;
      end
      if (rx_word_in) begin
        rbuf_reg <= {16'h0000, rx_hold_reg};
        receive_ready_flag_reg <= 1'b1;
      end else if (rd_rbuf) begin
        receive_ready_flag_reg <= 1'b0;
      end
    end
  end

  // checks
  property p_clk_half;
    @(posedge clk_sys) disable iff (!rst_b)
      clk_int && $changed(tclk_int_reg) |=> $stable(tclk_int_reg);
  endproperty
  a_clk_half: assert property (p_clk_half) else $error("data clock half period short");

  property p_fs_ext_quiet;
    @(posedge clk_sys) disable iff (!rst_b)
      transmit_frame_sync_o |-> fs_int && (tx_state_reg == dcs_pkg::TX_SYNC);
  endproperty
  a_fs_ext_quiet: assert property (p_fs_ext_quiet) else $error("frame sync out of place");

  property p_load_ready;
    @(posedge clk_sys) disable iff (!rst_b)
      tx_load |=> transmit_ready_flag_reg && xsr_full_reg && (xsr_reg == $past(xbuf_reg[15:0]));
  endproperty
  a_load_ready: assert property (p_load_ready) else $error("load did not set ready");

  property p_tx_int;
    @(posedge clk_sys) disable iff (!rst_b)
      $rose(transmit_ready_flag_reg) && cpu_tx_int_en && gctl_reg[dcs_pkg::GCTL_XINT_EN_BIT]
      |=> tx_int_flag ##1 !tx_int_flag;
  endproperty
  a_tx_int: assert property (p_tx_int) else $error("transmit flag not pulsed");

  property p_tx_len;
    @(posedge clk_sys) disable iff (!rst_b)
      tx_state_reg == dcs_pkg::TX_SHIFT && tx_tick && tx_cnt_reg == dcs_pkg::LAST_BIT
      |=> tx_state_reg == dcs_pkg::TX_IDLE && !xsr_full_reg;
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("word not 16 bits");

  property p_dx_source;
    @(posedge clk_sys) disable iff (!rst_b)
      transmit_data_pin |-> tx_state_reg == dcs_pkg::TX_SHIFT;
  endproperty
  a_dx_source: assert property (p_dx_source) else $error("data pin driven outside shift");

  property p_rx_copy;
    @(posedge clk_sys) disable iff (!rst_b)
      rx_word_in |=> receive_ready_flag_reg && (rbuf_reg[15:0] == $past(rx_hold_reg));
  endproperty
  a_rx_copy: assert property (p_rx_copy) else $error("receive buffer not loaded");

  property p_rx_read;
    @(posedge clk_sys) disable iff (!rst_b)
      rd_rbuf && receive_ready_flag_reg && !rx_word_in |=> !receive_ready_flag_reg && $changed(ack_tgl_reg);
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("read did not free buffer");

  property p_rx_freeze;
    @(posedge receive_clock) disable iff (!rst_b)
      rx_state_reg == dcs_pkg::RX_HOLD && rx_pending |=> $stable(rsr_reg);
  endproperty
  a_rx_freeze: assert property (p_rx_freeze) else $error("frozen receiver moved");

  property p_rx_len;
    @(posedge receive_clock) disable iff (!rst_b)
      rx_state_reg == dcs_pkg::RX_SHIFT && rx_cnt_reg == dcs_pkg::LAST_BIT
      |=> rx_state_reg != dcs_pkg::RX_SHIFT;
  endproperty
  a_rx_len: assert property (p_rx_len) else $error("received word not 16 bits");

endmodule : dcs_serial_port

/* File: bench/dcs_conv_model.sv */
// converter-side model: gated link clock, frame sync and serial result word
// assumes link_clk runs free; the port sees it only during a burst
`timescale 1ns/1ns
module dcs_conv_model (
  // free link clock and burst request
  input  wire logic        link_clk,
  input  wire logic        go,
  input  wire logic        framed,
  input  wire logic [15:0] word,
  // converter pins toward the port
  output logic             conv_clk,
  output logic             conv_fs,
  output logic             conv_sdo,
  output logic             busy
);
  int          cnt;
  logic        run;
  logic [15:0] sh;

  // clock stands low outside a burst
  assign conv_clk = link_clk & run;

  initial begin
    cnt      = 0;
    run      = 1'b0;
    sh       = 16'h0000;
    conv_fs  = 1'b0;
    conv_sdo = 1'b0;
    busy     = 1'b0;
  end

  // launch on falling edge, port samples on rising
  always @(negedge link_clk) begin
    if (!busy && go) begin
      busy    <= 1'b1;
      run     <= 1'b1;
      sh      <= word;
      cnt     <= 1;
      conv_fs <= framed;
    end else if (busy) begin
      conv_fs  <= 1'b0;
      // released line toggles each clock, starting from the inverse of the last bit
      conv_sdo <= (cnt <= 16) ? sh[16 - cnt] : ~conv_sdo;
      cnt      <= cnt + 1;
      if (cnt == 20) begin
        run  <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule : dcs_conv_model

/* File: bench/testbench.sv */
// self-checking bench: registers, transmit framing, receive and freeze
// assumes the converter model drives the receive pins from a 48 ns clock
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  localparam int          LIMIT    = 20000;
  localparam logic [31:0] GCTL_SET = 32'h0C140044;
  logic                  clk_sys;
  logic                  rst_b;
  logic                  link_clk;
  logic                  cpu_tx_int_en;
  logic                  cpu_rx_int_en;
  logic                  go;
  logic                  framed;
  logic                  ext_clk;
  logic                  ext_fs;
  dcs_pkg::dcs_bus_req_t bus_req;
  logic [31:0]           bus_rdata;
  logic [31:0]           rd_val;
  logic [31:0]           lfsr;
  logic [15:0]           word;
  logic [15:0]           w1;
  logic [15:0]           w2;
  logic [15:0]           w3;
  logic                  tx_int_flag;
  logic                  rx_int_flag;
  logic                  tclk_o;
  logic                  tclk_oe;
  logic                  fs_o;
  logic                  fs_oe;
  logic                  dx;
  logic                  rclk;
  logic                  rfs;
  logic                  rdat;
  logic                  busy;
  int                    bad_count;
  int                    check_count;
  int                    cyc;
  int                    tx_pulses;
  int                    rx_pulses;
  logic [23:0] zero_regs [8] = '{24'h808042, 24'h808043, 24'h808044, 24'h808045,
                                 24'h808046, 24'h80804C, 24'h808048, 24'h808041};
  logic [31:0] setup_val [5] = '{32'h00000111, 32'h00000111, 32'h000001CF,
                                 32'h00000000, 32'h00000000};

  dcs_serial_port DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .cpu_tx_int_en(cpu_tx_int_en), .cpu_rx_int_en(cpu_rx_int_en),
    .tx_int_flag(tx_int_flag), .rx_int_flag(rx_int_flag),
    .transmit_clock_i(ext_clk), .transmit_clock_o(tclk_o), .transmit_clock_oe(tclk_oe),
    .transmit_frame_sync_i(ext_fs), .transmit_frame_sync_o(fs_o),
    .transmit_frame_sync_oe(fs_oe), .transmit_data_pin(dx),
    .receive_clock(rclk), .receive_frame_sync(rfs), .receive_data_pin(rdat));
  dcs_conv_model conv (.link_clk(link_clk), .go(go), .framed(framed), .word(word),
    .conv_clk(rclk), .conv_fs(rfs), .conv_sdo(rdat), .busy(busy));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  // flags sampled mid-cycle, away from their launching edge
  always @(negedge clk_sys) begin
    cyc++;
    if (tx_int_flag === 1'b1) tx_pulses++;
    if (rx_int_flag === 1'b1) rx_pulses++;
    if (cyc == LIMIT) begin
      bad_count++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic logic [31:0] gctl_exp(input logic xr, input logic rr);
    return {GCTL_SET[31:2], xr, rr};
  endfunction : gctl_exp

  task automatic bus_wr(input logic [23:0] a, input logic [31:0] d);
    bus_req.wr    <= 1'b1;
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    @(posedge clk_sys);
    #1;
    bus_req.wr <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : bus_wr
  task automatic rd_chk(input logic [23:0] a, input logic [31:0] e);
    bus_req.rd   <= 1'b1;
    bus_req.addr <= a;
    @(posedge clk_sys);
    #1;
    bus_req.rd <= 1'b0;
    @(posedge clk_sys);
    #1;
    rd_val = bus_rdata;
    `CHK(rd_val, e)
  endtask : rd_chk
  task automatic tx_expect(input logic [15:0] w);
    logic [15:0] got;
    int          n;
    n = 0;
    while (fs_o !== 1'b1 && n < 200) begin
      @(posedge tclk_o);
      n++;
    end
    for (int i = 15; i >= 0; i--) begin
      @(posedge tclk_o);
      got[i] = dx;
    end
    @(posedge tclk_o);
    `CHK(got, w)
    `CHK(dx, 1'b0)
  endtask : tx_expect
  // external clock and frame sync: slow clock, sync high for the first tick
  task automatic ext_tx(input logic [15:0] w);
    logic [15:0] got;
    ext_fs <= 1'b1;
    for (int k = 0; k < 18; k++) begin
      repeat (4) @(posedge clk_sys);
      #1;
      ext_clk <= 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      ext_clk <= 1'b1;
      ext_fs  <= 1'b0;
      if (k > 0 && k < 17) got[16 - k] = dx;
    end
    `CHK(got, w)
    `CHK(dx, 1'b0)
  endtask : ext_tx
  task automatic rx_send(input logic [15:0] w, input logic f);
    int n;
    word   <= w;
    framed <= f;
    go     <= 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    go <= 1'b0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : rx_send
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    rst_b = 1'b0;
    bus_req = '0;
    cpu_tx_int_en = 1'b0;
    cpu_rx_int_en = 1'b0;
    go = 1'b0;
    framed = 1'b0;
    ext_clk = 1'b1;
    ext_fs = 1'b0;
    word = 16'h0000;
    bad_count = 0;
    check_count = 0;
    cyc = 0;
    tx_pulses = 0;
    rx_pulses = 0;
    lfsr = 32'h000121CB;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK({tclk_oe, fs_oe, dx}, 3'b000)
    rd_chk(dcs_pkg::ADDR_GCTL, 32'h00000002);
    foreach (zero_regs[i]) rd_chk(zero_regs[i], 32'h00000000);
    bus_wr(24'h808041, 32'hFFFFFFFF);
    rd_chk(24'h808041, 32'h00000000);
    lfsr = lfsr_next(lfsr);
    bus_wr(dcs_pkg::ADDR_TPRD, lfsr);
    rd_chk(dcs_pkg::ADDR_TPRD, lfsr);
    foreach (setup_val[i]) begin
      bus_wr(zero_regs[i], setup_val[i]);
      rd_chk(zero_regs[i], setup_val[i]);
    end
    lfsr = lfsr_next(lfsr);
    bus_wr(dcs_pkg::ADDR_XBUF, {16'h0000, lfsr[15:0]});
    ext_tx(lfsr[15:0]);
    bus_wr(dcs_pkg::ADDR_GCTL, GCTL_SET);
    cpu_tx_int_en <= 1'b1;
    cpu_rx_int_en <= 1'b1;
    `CHK({tclk_oe, fs_oe}, 2'b11)
    rd_chk(dcs_pkg::ADDR_GCTL, gctl_exp(1'b1, 1'b0));
    // every register-select code, random speed, power and data
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      w1 = {i[1], lfsr[14:13], i[0], lfsr[11:0]};
      fork
        tx_expect(w1);
        bus_wr(dcs_pkg::ADDR_XBUF, {16'h0000, w1});
      join
    end
    lfsr = lfsr_next(lfsr);
    w1 = {dcs_pkg::ADC_CMD_CONFIG, lfsr[11:0]};
    w2 = lfsr[31:16];
    fork
      begin
        tx_expect(w1);
        tx_expect(w2);
      end
      begin
        bus_wr(dcs_pkg::ADDR_XBUF, {16'h0000, w1});
        repeat (3) @(posedge clk_sys);
        #1;
        bus_wr(dcs_pkg::ADDR_XBUF, {16'h0000, w2});
        rd_chk(dcs_pkg::ADDR_GCTL, gctl_exp(1'b0, 1'b0));
      end
    join
    `CHK(tx_pulses, 6)
    lfsr = lfsr_next(lfsr);
    w1 = lfsr[15:0];
    rx_send(w1, 1'b1);
    `CHK(rx_pulses, 1)
    rd_chk(dcs_pkg::ADDR_RBUF, {16'h0000, w1});
    rd_chk(dcs_pkg::ADDR_GCTL, gctl_exp(1'b1, 1'b0));
    lfsr = lfsr_next(lfsr);
    w2 = lfsr[15:0];
    w3 = lfsr[31:16];
    // unread buffer: second word freezes, third is ignored
    rx_send(w2, 1'b1);
    rx_send(w3, 1'b1);
    rx_send(~w3, 1'b1);
    rd_chk(dcs_pkg::ADDR_GCTL, gctl_exp(1'b1, 1'b1));
    rd_chk(dcs_pkg::ADDR_RBUF, {16'h0000, w2});
    rx_send(16'h0000, 1'b0);
    rd_chk(dcs_pkg::ADDR_RBUF, {16'h0000, w3});
    `CHK(rx_pulses, 3)
    tally_and_finish();
  end
endmodule : testbench
